// [sfmon_top.sv]
// Servo fault monitor: fault qualification, latching and aggregation
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "sfmon_regs.svh"
module sfmon_top (
    input wire logic core_clk, // Clock, 100 MHz
    input wire logic rstn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic [15:0] ana_dmd_ua, // Analog demand current, uA
    input wire logic [15:0] bus_dmd, // Fieldbus demand, 0.01 %
    input wire logic [15:0] pos_dmd, // Resolved position demand
    input wire logic [15:0] pos1, // Position channel 1
    input wire logic [15:0] pos2, // Position channel 2
    input wire logic [15:0] fb1a_mv, // Feedback 1A input
    input wire logic [15:0] fb1b_mv, // Feedback 1B input
    input wire logic [15:0] fb2a_mv, // Feedback 2A input
    input wire logic [15:0] fb2b_mv, // Feedback 2B input
    input wire logic [15:0] drv_cmd, // Commanded driver current
    input wire logic [15:0] drv_meas, // Measured driver current
    input wire logic [15:0] exc_mv, // Excitation voltage, mV rms
    input wire logic [15:0] supply_mv, // Supply voltage, mV
    input wire logic coil_open, // Coil open detected
    input wire logic coil_short, // Coil short detected
    input wire logic fb1_open, // Feedback 1 wire open
    input wire logic fb2_open, // Feedback 2 wire open
    input wire logic ext_sd_closed, // External contact closed
    input wire logic internal_fail, // Self-test failure
    input wire logic no_operational, // No operational command yet
    input wire logic msg_timeout, // Demand or sync messages late
    input wire logic bus_error, // Bus cannot communicate
    input wire logic dnet_dup_id, // Duplicate node id
    input wire logic dnet_idle, // Master idle
    input wire logic bus_sd_cmd, // Shutdown command from master
    output logic alarm_out, // Aggregate alarm status
    output logic shutdown_out // Hardware shutdown status
);
    import sfmon_pkg::*;

    typedef struct packed {
        sfmon_vec_t type_sd;
        sfmon_vec_t latch_en;
        sfmon_vec_t active;
        logic [4:0] ctrl;
        logic [15:0] thr_trk1;
        logic [15:0] thr_trk2;
        logic [15:0] thr_perr1;
        logic [15:0] thr_perr2;
        logic [15:0] thr_dtrk;
        logic [15:0] thr_fb;
        logic [15:0] thr_pos;
        logic [15:0] dly_trk1;
        logic [15:0] dly_trk2;
        logic [15:0] dly_perr1;
        logic [15:0] dly_perr2;
        logic [15:0] dly_dtrk;
        logic [15:0] cal_lo;
        logic [15:0] cal_hi;
        logic [15:0] exc_cfg;
        logic [16:0] div;
        logic tick;
        sfmon_bus_t bus;
        sfmon_word_t rdata;
        logic alarm;
        logic shutdown;
    } sfmon_st_t;
    sfmon_st_t st_ff, nxt_st;

    localparam logic [16:0] TICK_DIV = `SFM_TICK_DIV; // 1 ms at 100 MHz

    function automatic logic [15:0] absdiff(input logic [15:0] a,
                                            input logic [15:0] b);
        absdiff = (a > b) ? a - b : b - a;
    endfunction

    function automatic logic outside(input logic [15:0] v,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi,
                                     input logic [15:0] thr);
        logic [16:0] lo_w, hi_w;
        lo_w = {1'b0, lo};
        hi_w = {1'b0, hi} + {1'b0, thr};
        outside = ({1'b0, v} + {1'b0, thr} < lo_w) || ({1'b0, v} > hi_w);
    endfunction

    function automatic logic [15:0] pct_fs(input logic [15:0] pct);
        logic [31:0] p;
        p = ({16'h0000, `SFM_DRV_FS} * {16'h0000, pct}) /
            {16'h0000, `SFM_PCT_DEN};
        pct_fs = p[15:0];
    endfunction

    // Raw causes and qualified delay faults
    logic [`SFM_NTIMER-1:0] tmr_raw;
    logic [`SFM_NTIMER-1:0] tmr_q;
    logic [15:0] tmr_dly [`SFM_NTIMER];
    sfmon_vec_t cause, eff_type, eff_latch;
    logic fb1_any, fb2_any, ana_bad, comm_bad, bus_dmd_cfg;

    assign tmr_raw[0] = absdiff(pos1, pos2) > st_ff.thr_trk1;
    assign tmr_raw[1] = absdiff(pos1, pos2) > st_ff.thr_trk2;
    assign tmr_raw[2] = absdiff(pos_dmd, pos1) > st_ff.thr_perr1;
    assign tmr_raw[3] = absdiff(pos_dmd, pos1) > st_ff.thr_perr2;
    assign tmr_raw[4] = absdiff(ana_dmd_ua, bus_dmd) > st_ff.thr_dtrk;
    assign tmr_dly[0] = st_ff.dly_trk1;
    assign tmr_dly[1] = st_ff.dly_trk2;
    assign tmr_dly[2] = st_ff.dly_perr1;
    assign tmr_dly[3] = st_ff.dly_perr2;
    assign tmr_dly[4] = st_ff.dly_dtrk;

    genvar gi;
    generate
        for (gi = 0; gi < `SFM_NTIMER; gi++) begin : g_qual
            sfmon_qual u_qual (
                .core_clk(core_clk),
                .rstn(rstn),
                .tick(st_ff.tick),
                .raw(tmr_raw[gi]),
                .delay_ms(tmr_dly[gi]),
                .qual(tmr_q[gi])
            );
        end
    endgenerate

    assign bus_dmd_cfg = st_ff.ctrl[`SFM_CTRL_SRC_BUS];

    always_comb begin
        cause = '0;
        ana_bad = (ana_dmd_ua < `SFM_ANA_MIN) ||
                  (ana_dmd_ua > `SFM_ANA_MAX);
        cause[`SFM_F_ANA_RANGE] = ana_bad;
        cause[`SFM_F_DRV_CUR] = absdiff(drv_meas, drv_cmd) >
            pct_fs(`SFM_DRV_CUR_PCT);
        cause[`SFM_F_DRV_OVC] = (drv_meas > drv_cmd) &&
            (drv_meas - drv_cmd > pct_fs(`SFM_DRV_OVC_PCT));
        cause[`SFM_F_DRV_OPEN] = coil_open;
        // Short sensing is unreliable at low demand
        cause[`SFM_F_DRV_SHORT] = coil_short &&
            (drv_cmd >= `SFM_SHORT_MIN);
        cause[`SFM_F_EXC] = absdiff(exc_mv, st_ff.exc_cfg) >
            `SFM_EXC_TOL;
        cause[`SFM_F_EXT_SD] = !ext_sd_closed;
        cause[`SFM_F_SUPPLY] = (supply_mv < `SFM_SUP_MIN) ||
            (supply_mv > `SFM_SUP_MAX);
        cause[`SFM_F_INTERNAL] = internal_fail;
        cause[`SFM_F_FB1] = fb1_open;
        cause[`SFM_F_FB2] = fb2_open;
        cause[`SFM_F_FB1_RNG] =
            outside(fb1a_mv, st_ff.cal_lo, st_ff.cal_hi, st_ff.thr_fb) ||
            outside(fb1b_mv, st_ff.cal_lo, st_ff.cal_hi, st_ff.thr_fb);
        cause[`SFM_F_FB2_RNG] =
            outside(fb2a_mv, st_ff.cal_lo, st_ff.cal_hi, st_ff.thr_fb) ||
            outside(fb2b_mv, st_ff.cal_lo, st_ff.cal_hi, st_ff.thr_fb);
        cause[`SFM_F_POS1_RNG] = outside(pos1, 16'h0000, `SFM_POS_FULL,
            st_ff.thr_pos);
        cause[`SFM_F_POS2_RNG] = outside(pos2, 16'h0000, `SFM_POS_FULL,
            st_ff.thr_pos);
        fb1_any = fb1_open || cause[`SFM_F_FB1_RNG] ||
            cause[`SFM_F_POS1_RNG] || cause[`SFM_F_EXC];
        fb2_any = fb2_open || cause[`SFM_F_FB2_RNG] ||
            cause[`SFM_F_POS2_RNG] || cause[`SFM_F_EXC];
        cause[`SFM_F_FB_ALL] = st_ff.ctrl[`SFM_CTRL_FB_TWO] ?
            (fb1_any && fb2_any) : fb1_any;
        cause[`SFM_F_TRK1] = tmr_q[0];
        cause[`SFM_F_TRK2] = tmr_q[1];
        cause[`SFM_F_PERR1] = tmr_q[2];
        cause[`SFM_F_PERR2] = tmr_q[3];
        cause[`SFM_F_DMD_TRK] = tmr_q[4] &&
            st_ff.ctrl[`SFM_CTRL_SRC_ANA] && bus_dmd_cfg;
        comm_bad = no_operational || msg_timeout || bus_error;
        if (st_ff.ctrl[`SFM_CTRL_BUS_DNET]) begin
            comm_bad = comm_bad || dnet_dup_id || dnet_idle;
        end
        cause[`SFM_F_COMM] = comm_bad;
        cause[`SFM_F_DMD_LOSS] =
            (st_ff.ctrl[`SFM_CTRL_SRC_ANA] && bus_dmd_cfg) ?
                (ana_bad && comm_bad) :
            st_ff.ctrl[`SFM_CTRL_SRC_ANA] ? ana_bad :
            bus_dmd_cfg ? comm_bad : 1'b0;
        cause[`SFM_F_BUS_SD] = bus_sd_cmd;
    end

    // Fixed kinds override the configuration bits
    assign eff_type = (st_ff.type_sd & `SFM_CFG_TYPE) |
        `SFM_FORCE_SD;
    assign eff_latch = (st_ff.latch_en | `SFM_FORCE_LT) &
        ~`SFM_FORCE_NL;

    logic wr_en;
    logic rd_en;
    logic rst_cmd;
    logic [31:0] rd_mux;
    logic addr_ok;
    sfmon_vec_t alarm_vec, sd_vec;

    // An enable without its setup cycle writes nothing
    assign wr_en = psel && penable && pwrite &&
        (st_ff.bus == SFMON_ACCESS);
    assign rd_en = psel && !penable && !pwrite;
    assign rst_cmd = wr_en && (paddr == `SFM_ADDR_CTRL) &&
        pwdata[`SFM_CTRL_RESET];

    always_comb begin
        addr_ok = 1'b1;
        unique case (paddr)
            `SFM_ADDR_CTRL: rd_mux = {27'h0, st_ff.ctrl};
            `SFM_ADDR_TYPE: rd_mux = {8'h00, st_ff.type_sd};
            `SFM_ADDR_LATCH: rd_mux = {8'h00, st_ff.latch_en};
            `SFM_ADDR_STATUS: rd_mux = {30'h0, st_ff.shutdown, st_ff.alarm};
            `SFM_ADDR_ACTIVE: rd_mux = {8'h00, st_ff.active};
            `SFM_ADDR_DMD: rd_mux = {st_ff.thr_dtrk, st_ff.dly_dtrk};
            `SFM_ADDR_MEAS: rd_mux = {st_ff.thr_trk1, st_ff.thr_trk2};
            `SFM_ADDR_FB: rd_mux = {st_ff.thr_fb, st_ff.thr_pos};
            `SFM_ADDR_THR: rd_mux = {st_ff.thr_perr1, st_ff.thr_perr2};
            `SFM_ADDR_DLY: rd_mux = {st_ff.dly_perr1, st_ff.dly_perr2};
            `SFM_ADDR_FBCAL: rd_mux = {st_ff.cal_hi, st_ff.cal_lo};
            `SFM_ADDR_EXC: rd_mux = {st_ff.dly_trk1, st_ff.exc_cfg};
            default: begin
                rd_mux = 32'h0000_0000;
                addr_ok = 1'b0;
            end
        endcase
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = (st_ff.div == TICK_DIV);
        nxt_st.div = nxt_st.tick ? 17'h00000 : st_ff.div + 17'h00001;
        nxt_st.ctrl[`SFM_CTRL_RESET] = 1'b0;
        // Cause presence wins over the reset command; latched bits need both
        for (int i = 0; i < `SFM_NFAULT; i++) begin
            if (cause[i]) begin
                nxt_st.active[i] = 1'b1;
            end else if (!eff_latch[i] || rst_cmd) begin
                nxt_st.active[i] = 1'b0;
            end
        end
        if (rd_en) begin
            nxt_st.rdata = rd_mux;
        end
        if (wr_en) begin
            unique case (paddr)
                `SFM_ADDR_CTRL: nxt_st.ctrl = {pwdata[4:1], 1'b0};
                `SFM_ADDR_TYPE: nxt_st.type_sd = pwdata[23:0];
                `SFM_ADDR_LATCH: nxt_st.latch_en = pwdata[23:0];
                `SFM_ADDR_DMD: begin
                    nxt_st.thr_dtrk = pwdata[31:16];
                    nxt_st.dly_dtrk = pwdata[15:0];
                end
                `SFM_ADDR_MEAS: begin
                    nxt_st.thr_trk1 = pwdata[31:16];
                    nxt_st.thr_trk2 = pwdata[15:0];
                end
                `SFM_ADDR_FB: begin
                    nxt_st.thr_fb = pwdata[31:16];
                    nxt_st.thr_pos = pwdata[15:0];
                end
                `SFM_ADDR_THR: begin
                    nxt_st.thr_perr1 = pwdata[31:16];
                    nxt_st.thr_perr2 = pwdata[15:0];
                end
                `SFM_ADDR_DLY: begin
                    nxt_st.dly_perr1 = pwdata[31:16];
                    nxt_st.dly_perr2 = pwdata[15:0];
                end
                `SFM_ADDR_FBCAL: begin
                    nxt_st.cal_hi = pwdata[31:16];
                    nxt_st.cal_lo = pwdata[15:0];
                end
                `SFM_ADDR_EXC: begin
                    nxt_st.dly_trk1 = pwdata[31:16];
                    nxt_st.dly_trk2 = pwdata[31:16];
                    nxt_st.exc_cfg = pwdata[15:0];
                end
                default: nxt_st.ctrl = st_ff.ctrl;
            endcase
        end
        alarm_vec = st_ff.active & ~eff_type;
        sd_vec = st_ff.active & eff_type;
        // Comm fault only informs unless the bus supplies demand
        if (!bus_dmd_cfg) begin
            alarm_vec[`SFM_F_COMM] = 1'b0;
            sd_vec[`SFM_F_COMM] = 1'b0;
        end
        nxt_st.alarm = |alarm_vec;
        nxt_st.shutdown = |sd_vec;
        nxt_st.bus = (psel && !penable) ? SFMON_ACCESS : SFMON_IDLE;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '0;
            st_ff.type_sd <= `SFM_TYPE_RST;
            st_ff.latch_en <= `SFM_LATCH_RST;
            st_ff.ctrl <= `SFM_CTRL_RST;
            st_ff.cal_hi <= `SFM_CAL_HI_RST;
            st_ff.thr_fb <= 16'h0000;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Zero wait state: read data latched in setup, valid in access
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign prdata = st_ff.rdata;
    assign alarm_out = st_ff.alarm;
    assign shutdown_out = st_ff.shutdown;
endmodule
`default_nettype wire

// [sfmon_regs.svh]
// Register map and field constants of the servo fault monitor
`ifndef SFMON_REGS_SVH
`define SFMON_REGS_SVH

`define SFM_ADDR_CTRL 12'h000
`define SFM_ADDR_TYPE 12'h004
`define SFM_ADDR_LATCH 12'h008
`define SFM_ADDR_STATUS 12'h00C
`define SFM_ADDR_ACTIVE 12'h010
`define SFM_ADDR_DMD 12'h014
`define SFM_ADDR_MEAS 12'h018
`define SFM_ADDR_FB 12'h01C
`define SFM_ADDR_THR 12'h020
`define SFM_ADDR_DLY 12'h024
`define SFM_ADDR_FBCAL 12'h028
`define SFM_ADDR_EXC 12'h02C

// Control register bits
`define SFM_CTRL_RESET 0
`define SFM_CTRL_FB_TWO 1
`define SFM_CTRL_SRC_ANA 2
`define SFM_CTRL_SRC_BUS 3
`define SFM_CTRL_BUS_DNET 4

// Fault indices
`define SFM_F_ANA_RANGE 0
`define SFM_F_DRV_CUR 1
`define SFM_F_DRV_OVC 2
`define SFM_F_DRV_OPEN 3
`define SFM_F_DRV_SHORT 4
`define SFM_F_EXC 5
`define SFM_F_EXT_SD 6
`define SFM_F_SUPPLY 7
`define SFM_F_INTERNAL 8
`define SFM_F_FB1 9
`define SFM_F_FB2 10
`define SFM_F_FB_ALL 11
`define SFM_F_FB1_RNG 12
`define SFM_F_FB2_RNG 13
`define SFM_F_TRK1 14
`define SFM_F_TRK2 15
`define SFM_F_PERR1 16
`define SFM_F_PERR2 17
`define SFM_F_DMD_TRK 18
`define SFM_F_POS1_RNG 19
`define SFM_F_POS2_RNG 20
`define SFM_F_DMD_LOSS 21
`define SFM_F_COMM 22
`define SFM_F_BUS_SD 23
`define SFM_NFAULT 24

// Type: 1 = shutdown. Fixed kinds override the register.
`define SFM_FORCE_SD 24'h8001C4
`define SFM_FORCE_AL 24'h156400
`define SFM_CFG_TYPE 24'h2A9A3B
// Latching: 1 = latch. Fixed kinds override the register.
`define SFM_FORCE_LT 24'h00019E
`define SFM_FORCE_NL 24'h800040
`define SFM_TYPE_RST 24'h000000
`define SFM_LATCH_RST 24'h000000
`define SFM_CTRL_RST 5'h04
`define SFM_CAL_HI_RST 16'hFFFF

// Analog limits in uA, supply in mV, excitation in mV rms
`define SFM_ANA_MIN 16'd1000
`define SFM_ANA_MAX 16'd24000
`define SFM_SUP_MIN 16'd17000
`define SFM_SUP_MAX 16'd33000
`define SFM_EXC_TOL 16'd200
// Driver limits: percent of full-scale current
`define SFM_DRV_FS 16'd1000
`define SFM_DRV_CUR_PCT 16'd15
`define SFM_DRV_OVC_PCT 16'd20
`define SFM_PCT_DEN 16'd100
// Position full scale is 10000 (0.01 %)
`define SFM_POS_FULL 16'd10000
`define SFM_SHORT_MIN 16'd100
`define SFM_NTIMER 5
`define SFM_TICK_DIV 17'd99999

`endif

// [sfmon_pkg.sv]
// Types shared by the servo fault monitor
package sfmon_pkg;
    typedef logic [23:0] sfmon_vec_t;
    typedef logic [31:0] sfmon_word_t;
    typedef enum logic [1:0] {
        SFMON_IDLE = 2'b00,
        SFMON_ACCESS = 2'b01
    } sfmon_bus_t;
endpackage

// [sfmon_qual.sv]
// Persistence delay qualifier: output rises after input held for delay
`timescale 1ns/100ps
`default_nettype none
module sfmon_qual (
    input wire logic core_clk, // Clock
    input wire logic rstn, // Async reset, active low
    input wire logic tick, // Millisecond enable
    input wire logic raw, // Unqualified condition
    input wire logic [15:0] delay_ms, // Required duration
    output logic qual // Qualified condition
);
    typedef struct packed {
        logic [15:0] cnt;
        logic q;
    } sfmon_qst_t;
    sfmon_qst_t st_ff, nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (!raw) begin
            // Any interruption restarts the wait
            nxt_st.cnt = 16'h0000;
            nxt_st.q = 1'b0;
        end else if (st_ff.cnt >= delay_ms) begin
            nxt_st.q = 1'b1;
        end else if (tick) begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign qual = st_ff.q;
endmodule
`default_nettype wire

// [sfmon_plant.sv]
// Far-side model: coil, transducers and fieldbus master
`timescale 1ns/100ps
`default_nettype none
module sfmon_plant (
    input wire logic [15:0] pos, // True valve position
    input wire logic [15:0] ana, // Analog demand source, uA
    input wire logic [15:0] sup, // Supply rail, mV
    input wire logic [15:0] cmd, // Coil current command
    input wire logic [15:0] off, // Coil current error
    input wire logic [11:0] inj, // Injected far-side faults
    output logic [15:0] ana_ua, // Analog demand current
    output logic [15:0] bus_dmd, // Fieldbus demand
    output logic [15:0] pos_o, // Transducer positions
    output logic [15:0] fb_mv, // Transducer raw voltages
    output logic [15:0] meas, // Measured coil current
    output logic [15:0] exc, // Excitation, mV rms
    output logic [15:0] sup_mv, // Supply seen by device
    output logic [11:0] flg // Status lines, bench bit map
);
    assign ana_ua = ana;
    // Master demands where the valve sits, so tracking stays quiet
    assign bus_dmd = pos;
    assign pos_o = pos;
    assign fb_mv = 16'h1388; // Mid-span of the calibrated range
    assign meas = cmd + off; // Wraps for a negative error
    assign exc = 16'h1B58;
    assign sup_mv = sup;
    // Contact line is high when closed, so bit 4 is inverted
    assign flg[10:0] = inj[10:0] ^ 11'h010;
    assign flg[11] = inj[11];
endmodule
`default_nettype wire

// [sfmon_checker.sv]
// Port assertions for the servo fault monitor
`timescale 1ns/100ps
`default_nettype none
`include "sfmon_regs.svh"
module sfmon_checker (
    input wire logic core_clk, // Clock
    input wire logic rstn, // Reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [15:0] ana_dmd_ua, // Analog demand
    input wire logic [15:0] drv_cmd, // Coil command
    input wire logic [15:0] drv_meas, // Coil current
    input wire logic [15:0] supply_mv, // Supply
    input wire logic internal_fail, // Self-test failure
    input wire logic ext_sd_closed, // External contact
    input wire logic bus_sd_cmd, // Bus shutdown command
    input wire logic alarm_out, // Alarm status
    input wire logic shutdown_out // Shutdown status
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    logic clr_wr;
    logic any_out;
    logic [15:0] dif;
    logic [16:0] ovc_lim;
    assign clr_wr = psel && penable && pwrite &&
        paddr == `SFM_ADDR_CTRL && pwdata[`SFM_CTRL_RESET];
    assign any_out = alarm_out || shutdown_out;
    assign dif = drv_meas > drv_cmd ? drv_meas - drv_cmd
        : drv_cmd - drv_meas;
    assign ovc_lim = {1'b0, drv_cmd} + 17'h000C8;
    AST_ANA_RANGE: assert property ((ana_dmd_ua < `SFM_ANA_MIN ||
        ana_dmd_ua > `SFM_ANA_MAX) |-> ##2 any_out)
        else $error("analog range fault not shown");
    AST_DRV_CUR: assert property (dif > 16'h0096 |-> ##2 any_out)
        else $error("driver current fault not shown");
    AST_DRV_OVC: assert property ({1'b0, drv_meas} > ovc_lim
        |-> ##2 shutdown_out) else $error("overcurrent not shutdown");
    AST_EXT_SD: assert property (!ext_sd_closed |-> ##2 shutdown_out)
        else $error("open contact not shutdown");
    AST_SUPPLY: assert property ((supply_mv < `SFM_SUP_MIN ||
        supply_mv > `SFM_SUP_MAX) |-> ##2 shutdown_out)
        else $error("supply fault not shutdown");
    AST_INTERNAL: assert property (internal_fail |-> ##2
        shutdown_out) else $error("internal fault not shutdown");
    AST_BUS_SD: assert property (bus_sd_cmd |-> ##2 shutdown_out)
        else $error("bus shutdown command ignored");
    AST_LATCH: assert property (internal_fail ##1
        (!internal_fail && !clr_wr) [*4] |-> shutdown_out)
        else $error("latched shutdown dropped without reset");
    COV_LATCH: cover property (internal_fail ##1 !internal_fail [*4]);
    COV_ALARM: cover property (alarm_out && !shutdown_out);
    COV_CLEAR: cover property (clr_wr ##3 !shutdown_out);
endmodule
bind sfmon_top sfmon_checker chk_u (.core_clk(core_clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .ana_dmd_ua(ana_dmd_ua), .drv_cmd(drv_cmd),
    .drv_meas(drv_meas), .supply_mv(supply_mv),
    .internal_fail(internal_fail), .ext_sd_closed(ext_sd_closed),
    .bus_sd_cmd(bus_sd_cmd), .alarm_out(alarm_out),
    .shutdown_out(shutdown_out));
`default_nettype wire

// [tb.sv]
// Self-checking bench for the servo fault monitor
`timescale 1ns/100ps
`default_nettype none
`include "sfmon_regs.svh"
module tb;
    import sfmon_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, alarm_out, shutdown_out, err;
    logic [15:0] pos = 16'h1388;
    logic [15:0] ana = 16'h2EE0;
    logic [15:0] sup = 16'h5DC0;
    logic [15:0] cmd = 16'h01F4;
    logic [15:0] off = 16'h0000;
    logic [15:0] ra, ro, ana_ua, bus_dmd, pos_o, fb_mv, meas, exc, sup_mv;
    logic [11:0] inj = 12'h000;
    logic [11:0] flg;
    sfmon_word_t rd;
    int miscompares = 0;
    int compares = 0;
    int seed = 81;
    // Latch table: kind (0 supply, 1 current error, 2 line), value,
    // {held after cause goes, alarm, shutdown}
    int lk[14] = '{0, 0, 0, 0, 1, 1, 1, 1, 1, 2, 2, 2, 2, 2};
    logic [15:0] lv[14] = '{16'h4267, 16'h4268, 16'h80E8, 16'h80E9,
        16'h0096, 16'h0097, 16'h00C8, 16'h00C9, 16'hFF37, 16'h0005,
        16'h0000, 16'h0001, 16'h0004, 16'h000B};
    logic [2:0] le[14] = '{3'h5, 3'h0, 3'h0, 3'h5, 3'h0, 3'h6, 3'h6,
        3'h7, 3'h6, 3'h5, 3'h6, 3'h6, 3'h1, 3'h1};
    logic [15:0] cb[7] = '{16'h6, 16'h7, 16'h8, 16'h6, 16'h8, 16'h9, 16'hA};
    logic [31:0] cc[7] = '{32'hC, 32'hC, 32'hC, 32'h1C, 32'h1C, 32'h1C,
        32'h1C};

    always #5 core_clk = ~core_clk;

    sfmon_plant plant_u (.pos(pos), .ana(ana), .sup(sup), .cmd(cmd),
        .off(off), .inj(inj), .ana_ua(ana_ua), .bus_dmd(bus_dmd),
        .pos_o(pos_o), .fb_mv(fb_mv), .meas(meas), .exc(exc),
        .sup_mv(sup_mv), .flg(flg));

    sfmon_top dut_u (.core_clk(core_clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ana_dmd_ua(ana_ua), .bus_dmd(bus_dmd), .pos_dmd(pos_o),
        .pos1(pos_o), .pos2(pos_o), .fb1a_mv(fb_mv), .fb1b_mv(fb_mv),
        .fb2a_mv(fb_mv), .fb2b_mv(fb_mv), .drv_cmd(cmd), .drv_meas(meas),
        .exc_mv(exc), .supply_mv(sup_mv), .coil_open(flg[0]),
        .coil_short(flg[1]), .fb1_open(flg[2]), .fb2_open(flg[3]),
        .ext_sd_closed(flg[4]), .internal_fail(flg[5]),
        .no_operational(flg[6]), .msg_timeout(flg[7]), .bus_error(flg[8]),
        .dnet_dup_id(flg[9]), .dnet_idle(flg[10]), .bus_sd_cmd(flg[11]),
        .alarm_out(alarm_out), .shutdown_out(shutdown_out));

    function automatic logic [15:0] rnd(input logic [15:0] m);
        rnd = 16'($unsigned($random(seed)) % {16'h0, m});
    endfunction

    function automatic logic ana_bad(input logic [15:0] v);
        return v < `SFM_ANA_MIN || v > `SFM_ANA_MAX;
    endfunction

    task automatic test_done;
        if (miscompares == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            miscompares++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next request never lands in this time step
        @(posedge core_clk);
    endtask

    task automatic see(input logic a, input logic s);
        repeat (4) @(posedge core_clk);
        chk({30'h0, alarm_out, shutdown_out}, {30'h0, a, s});
    endtask

    task automatic put(input int k, input logic [15:0] v, input logic on);
        case (k)
            0: sup <= on ? v : 16'h5DC0;
            1: off <= on ? v : 16'h0000;
            default: inj[v[3:0]] <= on;
        endcase
    endtask

    initial begin
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        apb(1'b0, `SFM_ADDR_CTRL, 32'h0);
        chk(rd, 32'h4);
        apb(1'b0, `SFM_ADDR_TYPE, 32'h0);
        chk(rd, {8'h0, `SFM_TYPE_RST});
        apb(1'b0, `SFM_ADDR_LATCH, 32'h0);
        chk(rd, {8'h0, `SFM_LATCH_RST});
        apb(1'b0, 12'h030, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        // Wide limits and long delays keep the delayed faults quiet
        apb(1'b1, `SFM_ADDR_DMD, 32'hFFFFFFFF);
        apb(1'b1, `SFM_ADDR_MEAS, 32'hFFFFFFFF);
        apb(1'b1, `SFM_ADDR_FB, 32'h01F401F4);
        apb(1'b1, `SFM_ADDR_THR, 32'hFFFFFFFF);
        apb(1'b1, `SFM_ADDR_DLY, 32'hFFFFFFFF);
        apb(1'b1, `SFM_ADDR_FBCAL, 32'h232803E8);
        apb(1'b1, `SFM_ADDR_EXC, 32'hFFFF1B58);
        apb(1'b1, `SFM_ADDR_CTRL, 32'h5);
        see(1'b0, 1'b0);
        apb(1'b0, `SFM_ADDR_ACTIVE, 32'h0);
        chk(rd, 32'h0);
        foreach (lk[i]) begin
            put(lk[i], lv[i], 1'b1);
            see(le[i][1], le[i][0]);
            put(lk[i], lv[i], 1'b0);
            see(le[i][2] & le[i][1], le[i][2] & le[i][0]);
            apb(1'b1, `SFM_ADDR_CTRL, 32'h5);
            see(1'b0, 1'b0);
        end
        cmd <= 16'h0063;
        inj[1] <= 1'b1;
        see(1'b0, 1'b0);
        inj[1] <= 1'b0;
        cmd <= 16'h01F4;
        apb(1'b1, `SFM_ADDR_TYPE, 32'h2);
        chk(rd, 32'h0);
        apb(1'b0, `SFM_ADDR_TYPE, 32'h0);
        chk(rd, 32'h2);
        off <= 16'hFF69;
        see(1'b0, 1'b1);
        off <= 16'h0000;
        apb(1'b1, `SFM_ADDR_LATCH, 32'h1);
        ana <= 16'h03E7;
        see(1'b1, 1'b1);
        apb(1'b1, `SFM_ADDR_CTRL, 32'h5);
        see(1'b1, 1'b0);
        ana <= 16'h2EE0;
        see(1'b1, 1'b0);
        apb(1'b1, `SFM_ADDR_CTRL, 32'h5);
        see(1'b0, 1'b0);
        apb(1'b1, `SFM_ADDR_LATCH, 32'h0);
        apb(1'b1, `SFM_ADDR_TYPE, 32'h00200000);
        ana <= 16'h03E7;
        see(1'b1, 1'b1);
        apb(1'b1, `SFM_ADDR_CTRL, 32'hC);
        see(1'b1, 1'b0);
        inj[6] <= 1'b1;
        see(1'b1, 1'b1);
        inj[6] <= 1'b0;
        ana <= 16'h2EE0;
        apb(1'b1, `SFM_ADDR_TYPE, 32'h0);
        apb(1'b1, `SFM_ADDR_CTRL, 32'h5);
        see(1'b0, 1'b0);
        foreach (cb[i]) begin
            put(2, cb[i], 1'b1);
            see(1'b0, 1'b0);
            apb(1'b1, `SFM_ADDR_CTRL, cc[i]);
            see(1'b1, 1'b0);
            put(2, cb[i], 1'b0);
            apb(1'b1, `SFM_ADDR_CTRL, 32'h5);
            see(1'b0, 1'b0);
        end
        repeat (40) begin
            ra = rnd(16'h7530);
            ro = rnd(16'h012D) - 16'h0096;
            ana <= ra;
            off <= ro;
            pos <= rnd(16'h2711);
            cmd <= 16'h0096 + rnd(16'h02BC);
            see(ana_bad(ra), 1'b0);
        end
        test_done();
    end
endmodule
`default_nettype wire
